// ==== fsr_pkg.sv ====
// Constants, types and helpers of the fault supervisor.
// Assumes one 25 MHz clock and a 10 ms supervision tick.
package fsr_pkg;
   ////////////////////////////////////////////////////////////
   localparam int unsigned CLK_HZ   = 25000000;  // System clock
   localparam int unsigned TICK_MS  = 10;        // Supervision tick
   localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned NCODE    = 23;        // Codes 0..22
   localparam int unsigned NCH      = 7;         // Energy channels
   localparam int unsigned NRET     = 4;         // Retained channels
   localparam logic [22:0] CODE_MASK  = 23'h7f3ffe; // Used codes
   localparam logic [22:0] LATCH_MASK = 23'h7f3dfe; // All but 9
   localparam logic [22:0] WARN_MASK  = 23'h000031; // Temps, brake
   localparam int unsigned CODE_PWR = 9;         // Power input lost
   localparam logic [7:0] PCT_FULL = 8'h64;      // 100 percent
   localparam logic [7:0] PCT_WARN = 8'h32;      // 50 percent
   // Lock times in ms, tick counts derived
   localparam int unsigned LOCK_A_MS = 5000;
   localparam int unsigned LOCK_B_MS = 10000;
   localparam int unsigned LOCK_C_MS = 100000;
   localparam int unsigned LOCK_D_MS = 100;
   // Discharge time per percent in ms
   localparam int unsigned DIS_BRK_MS = 500;
   localparam int unsigned DIS_CAB_MS = 24800;
   localparam int unsigned DIS_DEV_MS = 150;
   localparam int unsigned DIS_CHN_MS = 180;
   localparam int unsigned EN_CODE [NCH] = '{8, 12, 21, 22, 7, 16, 17};
   localparam int unsigned EN_STEP [NCH] = '{DIS_BRK_MS / TICK_MS,
      DIS_BRK_MS / TICK_MS, DIS_CAB_MS / TICK_MS, DIS_CAB_MS / TICK_MS,
      DIS_DEV_MS / TICK_MS, DIS_CHN_MS / TICK_MS, DIS_CHN_MS / TICK_MS};
   // Register offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_STAT  = 8'h04;
   localparam logic [7:0] REG_DWARN = 8'h08;
   localparam logic [7:0] REG_LWARN = 8'h0c;
   localparam logic [7:0] REG_DFLT  = 8'h10;
   localparam logic [7:0] REG_LFLT  = 8'h14;
   localparam logic [7:0] REG_EN_LO = 8'h18;
   localparam logic [7:0] REG_EN_HI = 8'h1c;
   localparam int unsigned CTRL_AUTO = 0;        // Auto restart bit
   localparam int unsigned CTRL_RST  = 1;        // Reset errors bit
   typedef enum logic [3:0] {
      S_WAIT  = 4'b0001,                          // Mains wait
      S_CHECK = 4'b0010,                          // Bus voltage check
      S_OPER  = 4'b0100,                          // Operating or warning
      S_FAULT = 4'b1000
   } fsr_state_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fsr_req_t;
   // Lock time of one fault code, in ticks
   function automatic logic [13:0] fsr_lock(input int unsigned c);
      case (c)
         1, 2, 19:   fsr_lock = 14'(LOCK_A_MS / TICK_MS);
         11:         fsr_lock = 14'(LOCK_D_MS / TICK_MS);
         12, 21, 22: fsr_lock = 14'(LOCK_C_MS / TICK_MS);
         3, 4, 5, 6, 7, 8, 10, 16, 17, 18, 20:
                     fsr_lock = 14'(LOCK_B_MS / TICK_MS);
         default:    fsr_lock = 14'h0000;
      endcase
   endfunction
endpackage

// ==== fsr_supervisor.sv ====
// Fault supervisor and restore sequencer of a DC bus supply.
// Monitors, I2T energy and limits come from outside logic;
// rst_n is the control-supply power-on reset.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module fsr_supervisor
#(
   parameter int unsigned TICK_CYC = fsr_pkg::TICK_CYC_DEF
)
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Register port
   input  wire fsr_pkg::fsr_req_t   req,
   output logic [31:0]              rdata,
   // Monitor conditions, bit per code
   input  wire logic [22:0]         fault_cond,
   input  wire logic [22:0]         warn_cond,
   // Energy percentages and stored values
   input  wire logic [6:0][7:0]     energy_pct,
   input  wire logic [3:0][7:0]     nv_energy,
   // Start-up sequencing
   input  wire logic                mains_ok,
   input  wire logic                bus_ok,
   input  wire logic                restore_request_input,
   // Status outputs
   output logic                     ready_to_operate_output,
   output logic                     fault_active
);
   import fsr_pkg::*;

   ////////////////////////////////////////////////////////////
   // Elaboration check
   if (TICK_CYC < 2 || TICK_CYC > 262143)
   begin : g_bad
      $error("TICK_CYC out of range");
   end

   ////////////////////////////////////////////////////////////
   // Declarations
   fsr_state_t   state_r;            // Sequencer state
   fsr_state_t   state_nxt;
   logic [22:0]  lat_f_r;            // Latched faults
   logic [22:0]  lat_f_nxt;
   logic [22:0]  lat_w_r;            // Latched warnings
   logic [22:0]  lat_w_nxt;
   logic [22:0]  en_flt;             // Energy faults
   logic [22:0]  en_warn;            // Energy warnings
   logic [22:0]  en_busy_v;          // Codes still charged
   logic [7:0]   trk_r [NCH];        // Tracked energy
   logic [11:0]  dcy_r [NCH];        // Discharge step counters
   logic [17:0]  pre_r;              // Tick prescaler
   logic [13:0]  lock_r;             // Restore lock timer
   logic [13:0]  lock_nxt;
   logic [13:0]  lock_max;
   logic [4:0]   code_r;             // Active fault code
   logic [4:0]   code_low;
   logic         auto_r;             // Auto restart enable
   logic         pup_r;              // First cycle after reset
   logic         sync1_r;            // Restore synchroniser
   logic         sync2_r;
   logic         prev_r;             // Previous sample
   logic         rto_r;
   logic         flt_r;
   logic [31:0]  rdata_r;

   ////////////////////////////////////////////////////////////
   // Decode and condition wires
   wire         tick      = (pre_r == 18'(TICK_CYC - 1));
   wire [22:0]  cond_all  = (fault_cond | en_flt) & CODE_MASK;
   wire         cond_any  = |cond_all;
   wire [22:0]  dyn_w     = (warn_cond & WARN_MASK) | en_warn;
   wire         in_flt    = (state_r == S_FAULT);
   wire         monitored = (state_r == S_OPER) || (state_r == S_CHECK);
   wire         watch     = monitored || in_flt;
   wire         rise      = sync2_r & ~prev_r;
   wire         hit_ctrl  = (req.addr == REG_CTRL);
   wire         sw_rst    = req.wr && hit_ctrl && req.wdata[CTRL_RST];
   wire         en_busy   = |(en_busy_v & lat_f_r);
   wire         exit_ok   = !cond_any && lock_r == 14'h0000
                            && !en_busy;
   wire         need_req  = |(lat_f_r & LATCH_MASK);
   wire         restore   = auto_r || rise || sw_rst
                            || !need_req;
   wire         leaving   = in_flt && (state_nxt == S_WAIT);
   wire         entering  = !in_flt && (state_nxt == S_FAULT);

   ////////////////////////////////////////////////////////////
   // Energy tracking, one lane per channel
   for (genvar c = 0; c < NCH; c++)
   begin : g_en
      wire [7:0] in_p  = energy_pct[c];
      wire [7:0] nv_p  = (c < NRET) ? nv_energy[c % NRET] : 8'h00;
      wire       step  = tick && (dcy_r[c] == 12'(EN_STEP[c] - 1));
      // Step counter and tracked value
      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            trk_r[c] <= 8'h00;
            dcy_r[c] <= 12'h000;
         end
         else
         begin
            if (tick)
               dcy_r[c] <= step ? 12'h000 : dcy_r[c] + 12'h001;
            // Stored energy comes back at power-up
            if (pup_r && c < NRET)
               trk_r[c] <= nv_p;
            else if (in_p > trk_r[c])
               trk_r[c] <= in_p;
            // Never decays below what the monitor still reports
            else if (step && trk_r[c] > in_p)
               trk_r[c] <= trk_r[c] - 8'h01;
         end
      end
   end

   // Energy classes per fault code
   always_comb
   begin
      en_flt    = '0;
      en_warn   = '0;
      en_busy_v = '0;
      for (int c = 0; c < NCH; c++)
      begin
         // Fault at full, warning between half and full
         en_flt[EN_CODE[c]]    = (trk_r[c] >= PCT_FULL);
         en_warn[EN_CODE[c]]   = (trk_r[c] > PCT_WARN)
                                 && (trk_r[c] < PCT_FULL);
         en_busy_v[EN_CODE[c]] = (trk_r[c] != 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////
   // Longest lock time and lowest code
   always_comb
   begin
      lock_max = 14'h0000;
      code_low = 5'h00;
      for (int i = NCODE - 1; i > 0; i--)
      begin
         // Longest lock among detected faults
         if ((lat_f_r[i] || cond_all[i]) && fsr_lock(i) > lock_max)
            lock_max = fsr_lock(i);
         if (cond_all[i])
            code_low = 5'(i);
      end
   end

   ////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_WAIT:
            if (mains_ok)
               state_nxt = S_CHECK;
         S_CHECK:
            if (cond_any)
               state_nxt = S_FAULT;
            else if (bus_ok)
               state_nxt = S_OPER;
         S_OPER:
            if (cond_any)
               state_nxt = S_FAULT;
         S_FAULT:
            // Stays while any condition is present
            if (exit_ok && restore)
               state_nxt = S_WAIT;
         default:
            state_nxt = S_WAIT;
      endcase
   end

   // Lock timer: reloads while a condition stands
   assign lock_nxt = ((in_flt || entering) && cond_any) ? lock_max :
                     (tick && lock_r != 14'h0000) ? lock_r - 14'h0001 :
                     lock_r;

   // Latches, set wins over clear
   assign lat_f_nxt = (leaving ? 23'h000000 : lat_f_r)
                      | (watch ? (cond_all & LATCH_MASK) : 23'h000000);
   // Power input warning outlives the exit; only software clears it
   assign lat_w_nxt = (sw_rst  ? 23'h000000 :
                       leaving ? (lat_w_r & (23'h000001 << CODE_PWR)) : lat_w_r)
                      | dyn_w
                      | (watch ? (cond_all & (23'h000001 << CODE_PWR))
                               : 23'h000000);

   ////////////////////////////////////////////////////////////
   // Sequencer and status registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= S_WAIT;
         lock_r  <= 14'h0000;
         lat_f_r <= 23'h000000;
         lat_w_r <= 23'h000000;
         code_r  <= 5'h00;
         rto_r   <= 1'b0;
         flt_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         lock_r  <= lock_nxt;
         lat_f_r <= lat_f_nxt;
         lat_w_r <= lat_w_nxt;
         // Code caught on entry, cleared on exit
         if (entering)
            code_r <= code_low;
         else if (leaving)
            code_r <= 5'h00;
         rto_r   <= (state_nxt == S_OPER);
         flt_r   <= (state_nxt == S_FAULT);
      end
   end

   ////////////////////////////////////////////////////////////
   // Tick prescaler and power-up flag
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_r <= 18'h00000;
         pup_r <= 1'b1;
      end
      else
      begin
         pre_r <= tick ? 18'h00000 : pre_r + 18'h00001;
         pup_r <= 1'b0;
      end
   end

   // Restore input synchroniser and edge sample
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end
      else
      begin
         sync1_r <= restore_request_input;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   ////////////////////////////////////////////////////////////
   // Register port
   wire [31:0] stat_w = {2'b00, lock_r, 6'h00, rto_r, code_r, state_r};
   wire [31:0] lfl_w  = {9'h000, lat_f_r};
   wire [31:0] rd_mux =
      hit_ctrl                  ? {31'h0, auto_r} :
      (req.addr == REG_STAT)    ? stat_w :
      (req.addr == REG_DWARN)   ? {9'h000, dyn_w} :
      (req.addr == REG_LWARN)   ? {9'h000, lat_w_r} :
      (req.addr == REG_DFLT)    ? {9'h000, cond_all} :
      (req.addr == REG_LFLT)    ? lfl_w :
      (req.addr == REG_EN_LO)   ? {trk_r[3], trk_r[2], trk_r[1], trk_r[0]} :
      (req.addr == REG_EN_HI)   ? {8'h00, trk_r[6], trk_r[5], trk_r[4]} :
      32'h00000000;

   // Control write and read data
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         auto_r  <= 1'b0;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         if (req.wr && hit_ctrl)
            auto_r <= req.wdata[CTRL_AUTO];
         rdata_r <= req.rd ? rd_mux : 32'h00000000;
      end
   end

   assign rdata                   = rdata_r;
   assign ready_to_operate_output = rto_r;
   assign fault_active            = flt_r;

   ////////////////////////////////////////////////////////////
   // Assertions
   trip_fault_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      monitored && cond_any |=> state_r == S_FAULT)
      else $error("limit violation did not trip");

   rto_open_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      state_r == S_FAULT |-> !ready_to_operate_output && fault_active)
      else $error("ready output closed in fault");

   hold_fault_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_flt && cond_any |=> state_r == S_FAULT && lock_r == $past(lock_max))
      else $error("fault left with condition present");

   lock_wait_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_flt && lock_r != 14'h0000 |=> state_r == S_FAULT)
      else $error("fault left before lock expiry");

   latch_keep_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      !in_flt |=> (lat_f_r & $past(lat_f_r)) == $past(lat_f_r))
      else $error("latched fault lost outside fault");

   auto_exit_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_flt && exit_ok && auto_r |=> state_r == S_WAIT)
      else $error("auto restart did not return");

   edge_exit_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_flt && exit_ok && $rose(sync2_r) |=> state_r == S_WAIT)
      else $error("restore edge ignored");

   sw_exit_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_flt && exit_ok && sw_rst |=> state_r == S_WAIT ##1
      lat_f_r == 23'h000000 || state_r != S_WAIT)
      else $error("reset command ignored");

   warn_only_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      state_r == S_OPER && !cond_any && warn_cond[0]
      |=> state_r != S_FAULT)
      else $error("braking overvoltage forced fault");

   energy_full_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      monitored && (trk_r[0] >= PCT_FULL || trk_r[4] >= PCT_FULL)
      |=> state_r == S_FAULT)
      else $error("full energy did not trip");

   rd_pulse_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      !$past(req.rd) |-> rdata == 32'h00000000)
      else $error("read data outside its cycle");
endmodule

// ==== fsr_far_model.sv ====
// Far-side model: power-stage monitors, mains and bus checks, restore input.
// Assumes the bench commands it; every output moves on a rising clk edge.
`timescale 1ns/10ps
module fsr_far_model
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Bench commands
   input  wire logic [22:0]     trip_set,
   input  wire logic [22:0]     warn_set,
   input  wire logic [6:0][7:0] pct_set,
   input  wire logic            restore_go,
   // Monitor side of the supervisor
   output logic [22:0]          fault_cond,
   output logic [22:0]          warn_cond,
   output logic [6:0][7:0]      energy_pct,
   output logic                 mains_ok,
   output logic                 bus_ok,
   output logic                 restore_request_input
);
   logic [3:0] up_r;   // Power-up sequencing count
   logic [2:0] rq_r;   // Restore pulse count
   ////////////////////////////////////////////////////////////////////
   // Monitors follow the bench; mains then bus come up after power-up
   always_ff @(posedge clk)
   begin
      fault_cond <= trip_set;
      warn_cond  <= warn_set;
      energy_pct <= pct_set;
      up_r       <= !rst_n ? 4'h0 : up_r + 4'(up_r != 4'hf);
      mains_ok   <= up_r > 4'h4;
      bus_ok     <= up_r > 4'h8;
      rq_r       <= !rst_n ? 3'h0 : restore_go ? 3'h6 : rq_r - 3'(rq_r != 3'h0);
      // Low first, then a clean rise held for four cycles
      restore_request_input <= rq_r != 3'h0 && rq_r < 3'h5;
   end
endmodule

// ==== fault_supervisor_restore_tb.sv ====
// Self-checking bench of the fault supervisor, random with a fixed seed.
// Assumes fsr_pkg and the far-side model; tick shortened to 10 cycles.
`timescale 1ns/10ps
module fault_supervisor_restore_tb;
   import fsr_pkg::*;
   localparam int unsigned TK = 10;   // Cycles per supervision tick
   logic            clk, rst_n, restore_go;
   fsr_req_t        req;
   logic [31:0]     rdata, rv, rw;
   logic [22:0]     trip_set, warn_set, fault_cond, warn_cond, wb;
   logic [6:0][7:0] pct_set, energy_pct;
   logic [3:0][7:0] nv_energy;
   logic            mains_ok, bus_ok, restore_request_input;
   logic            ready_to_operate_output, fault_active;
   int              n_mismatch, compares, n;
   ////////////////////////////////////////////////////////////////////
   fsr_supervisor #(.TICK_CYC(TK)) fsr_supervisor_i
   (
      .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .fault_cond(fault_cond), .warn_cond(warn_cond),
      .energy_pct(energy_pct), .nv_energy(nv_energy),
      .mains_ok(mains_ok), .bus_ok(bus_ok),
      .restore_request_input(restore_request_input),
      .ready_to_operate_output(ready_to_operate_output),
      .fault_active(fault_active)
   );
   fsr_far_model fsr_far_model_i
   (
      .clk(clk), .rst_n(rst_n), .trip_set(trip_set), .warn_set(warn_set),
      .pct_set(pct_set), .restore_go(restore_go),
      .fault_cond(fault_cond), .warn_cond(warn_cond),
      .energy_pct(energy_pct), .mains_ok(mains_ok), .bus_ok(bus_ok),
      .restore_request_input(restore_request_input)
   );
   ////////////////////////////////////////////////////////////////////
   // Free-running 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Expected lock time of a fault code, in ticks
   function automatic int unsigned lock_ticks(input int unsigned c);
      case (c)
         1, 2, 19:   return LOCK_A_MS / TICK_MS;
         11:         return LOCK_D_MS / TICK_MS;
         12, 21, 22: return LOCK_C_MS / TICK_MS;
         9, 13:      return 0;
         default:    return LOCK_B_MS / TICK_MS;
      endcase
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Idle cycles, leaving just after an edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr    <= 1'b0;
      #1;
   endtask
   // Register read, data taken in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd   <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Bounded wait for ready (rdy) or for fault exit
   task automatic wait_for(input bit rdy, input int max, output int k);
      k = 0;
      while ((rdy ? ready_to_operate_output : !fault_active) !== 1'b1 && k < max)
      begin
         cyc(1);
         k++;
      end
      chk(32'(k < max), 32'h1);
   endtask
   // Trip one code from operation, check status, release the condition
   task automatic trip_run(input int unsigned c);
      trip_set <= 23'h1 << c;
      cyc(4 + $urandom % 20);
      rd(REG_STAT, rv);
      chk(32'(rv[9:0]), {22'h0, 1'b0, 5'(c), 4'h8});
      chk(32'(rv[29:16]), 32'(lock_ticks(c)));
      chk(32'(fault_active), 32'h1);
      trip_set <= '0;
   endtask
   // Restore request through the far-side model
   task automatic pulse_restore();
      restore_go <= 1'b1;
      cyc(1);
      restore_go <= 1'b0;
   endtask
   // Counts and verdict; ends the run
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      req = '0;
      trip_set = '0;
      warn_set = '0;
      pct_set = '0;
      restore_go = 1'b0;
      nv_energy = '0;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(81));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      // Reset values, unmapped address, bring-up
      rd(REG_STAT, rv);
      chk(32'(rv[9:0]), 32'h001);
      rd(8'h40, rv);
      chk(rv, 32'h0);
      wait_for(1, 300, n);
      $display("test reset done");
      // Unused codes do not trip
      for (int i = 0; i < 23; i++)
         if (i == 0 || i == 14 || i == 15)
         begin
            trip_set <= 23'h1 << i;
            cyc(2 + $urandom % 8);
            chk(32'(fault_active), 32'h0);
         end
      trip_set <= '0;
      $display("test unused codes done");
      // Code 1, auto restart: exit after the lock time, within one tick
      wr(REG_CTRL, 32'h1);
      rd(REG_CTRL, rv);
      chk(rv, 32'h1);
      trip_run(1);
      wait_for(0, 6000, n);
      chk(32'(n >= 499 * TK && n <= 500 * TK + 40), 32'h1);
      wait_for(1, 300, n);
      $display("test auto restart done");
      // Code 11 latched; early restore lost, later one accepted
      wr(REG_CTRL, 32'h0);
      trip_run(11);
      pulse_restore();
      cyc(10 * TK + 40);
      chk(32'(fault_active), 32'h1);
      rd(REG_LFLT, rv);
      rd(REG_DFLT, rw);
      chk(32'({rv[11], rw[11]}), 32'h2);
      pulse_restore();
      wait_for(0, 30, n);
      chk(32'(n >= 3), 32'h1);
      wait_for(1, 300, n);
      $display("test restore input done");
      // Code 13: no lock time, cleared by software command
      trip_run(13);
      cyc(4);
      rd(REG_STAT, rv);
      chk(32'({rv[29:16], rv[3:0]}), 32'h8);
      wr(REG_CTRL, 32'h2);
      wait_for(0, 10, n);
      rd(REG_LFLT, rv);
      chk(rv, 32'h0);
      wait_for(1, 300, n);
      $display("test reset command done");
      // Power input loss: dynamic, fresh start-up without request
      trip_run(9);
      rd(REG_DFLT, rv);
      chk(32'(rv[9]), 32'h1);
      wait_for(0, 30, n);
      wait_for(1, 300, n);
      rd(REG_LWARN, rv);
      chk(32'(rv[9]), 32'h1);
      $display("test power input done");
      // Warnings only: braking overvoltage and a temperature
      wb = ($urandom % 2) ? 23'h11 : 23'h21;
      warn_set <= wb;
      cyc(4);
      rd(REG_DWARN, rv);
      chk(rv, 32'(wb));
      warn_set <= '0;
      cyc(4);
      rd(REG_LWARN, rv);
      chk(rv, 32'(wb) | 32'h200);
      chk(32'(fault_active), 32'h0);
      wr(REG_CTRL, 32'h2);
      rd(REG_LWARN, rv);
      chk(rv, 32'h0);
      $display("test warnings done");
      // Device energy: 99 holds, 100 trips, exit waits for discharge
      wr(REG_CTRL, 32'h1);
      pct_set[4] <= 8'h63;
      cyc(6);
      chk(32'(fault_active), 32'h0);
      pct_set[4] <= 8'h64;
      cyc(4);
      rd(REG_STAT, rv);
      chk(32'(rv[9:0]), 32'h078);
      rd(REG_EN_HI, rv);
      chk(32'(rv[7:0]), 32'h64);
      pct_set[4] <= 8'h00;
      // Control power stays on while energy discharges
      wait_for(0, 17000, n);
      chk(32'(n >= 14800 && n <= 15400), 32'h1);
      wait_for(1, 300, n);
      $display("test energy done");
      // Control power loss mid-fault; retained brake energy at 60 percent
      wr(REG_CTRL, 32'h0);
      trip_run(1);
      nv_energy[0] <= 8'h3c;
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(2);
      rd(REG_STAT, rv);
      chk(32'({rv[29:16], rv[3:0]}), 32'h1);
      rd(REG_LFLT, rv);
      chk(rv, 32'h0);
      rd(REG_EN_LO, rv);
      chk(32'(rv[7:0]), 32'h3c);
      rd(REG_DWARN, rv);
      rd(REG_LWARN, rw);
      chk(32'(rv[8] | rw[8]), 32'h1);
      wait_for(1, 300, n);
      $display("test power loss done");
      give_verdict();
   end
endmodule
